// file: include/stack_cpu_defines.svh
// constants of the stack processor sequencer: widths, depths, opcodes, vectors
`ifndef STACK_CPU_DEFINES_SVH
`define STACK_CPU_DEFINES_SVH

`define CPU_WORD_W        24
`define CPU_OP_W          6
`define CPU_CORE_OP_W     5
`define CPU_IO_ADDR_W     4
`define CPU_IO_FLAG_BIT   5
`define CPU_IO_WRITE_BIT  4
`define CPU_BRANCH_W      18
`define CPU_IRQ_N         7
`define CPU_IRQ_IDX_W     3
`define CPU_DSTACK_DEPTH  16
`define CPU_RSTACK_DEPTH  32
`define CPU_RESET_PC      24'h000000
`define CPU_IRQ_VEC_BASE  24'h000001
`define CPU_RESET_WORD    24'h000000

`define OP_JUMP           5'h00
`define OP_RETURN         5'h01
`define OP_BRANCH_IF_ZERO 5'h02
`define OP_BRANCH_NO_CY   5'h03
`define OP_CALL           5'h04
`define OP_LOOP_NEXT      5'h05
`define OP_REPEAT_WORD    5'h06
`define OP_INTERRUPT_EXIT 5'h07
`define OP_ROTATE8        5'h08
`define OP_LOAD_INC       5'h09
`define OP_LITERAL        5'h0A
`define OP_STORE_INC      5'h0B
`define OP_LOAD           5'h0C
`define OP_STORE          5'h0D
`define OP_RESERVED       5'h0E
`define OP_STORE_ALT      5'h0F
`define OP_COMPLEMENT     5'h10
`define OP_SHIFT_LEFT     5'h11
`define OP_RIGHT_SHIFT    5'h12
`define OP_MUL_STEP       5'h13
`define OP_XOR            5'h14
`define OP_AND            5'h15
`define OP_NIP            5'h16
`define OP_ADD            5'h17
`define OP_POP_RET        5'h18
`define OP_FETCH_ADDR     5'h19
`define OP_DUP            5'h1A
`define OP_OVER           5'h1B
`define OP_PUSH_RET       5'h1C
`define OP_SET_ADDR       5'h1D
`define OP_IDLE           5'h1E
`define OP_DROP           5'h1F

`endif

// file: include/stack_cpu_pkg.sv
// types shared by the stack processor sequencer and its stacks
package stack_cpu_pkg;
`include "stack_cpu_defines.svh"

    typedef logic [`CPU_WORD_W-1:0] word_t;

    typedef enum logic [2:0] {
        SLOT_FETCH,
        SLOT_EXEC0,
        SLOT_EXEC1,
        SLOT_EXEC2,
        SLOT_EXEC3,
        SLOT_IRQ
    } slot_t;

    typedef struct packed {
        slot_t slot;
        word_t a;
        word_t i;
        word_t p;
        word_t r;
        word_t t;
        logic  carry;
        logic  irqMasked;
        logic  serialOut;
    } cpu_state_t;

    typedef struct packed {
        word_t addr;
        word_t wrData;
        logic  wrEn_b;
    } mem_req_t;

    typedef struct packed {
        logic [`CPU_IO_ADDR_W-1:0] addr;
        word_t                     wrData;
        logic                      wr;
        logic                      rd;
    } io_req_t;

endpackage : stack_cpu_pkg

// file: core/lifo_stack.sv
// shift-register stack sitting below a top-of-stack register
`timescale 1ns/1ns
`include "stack_cpu_defines.svh"
module lifo_stack
    import stack_cpu_pkg::*;
#(
    parameter int DEPTH = `CPU_DSTACK_DEPTH
) (
    // clock and reset
    input  wire logic  clock,
    input  wire logic  rst_b,
    // stack control
    input  wire logic  push,
    input  wire logic  pop,
    input  wire word_t pushData,
    output word_t      top
);

    typedef struct packed {
        logic [DEPTH-1:0][`CPU_WORD_W-1:0] entry;
    } stack_state_t;

    stack_state_t q;
    stack_state_t d;

    // push and pop together replace the top entry in place
    always_comb begin
        d = q;
        if (push && pop) begin
            d.entry[0] = pushData;
        end else if (push) begin
            // overflow silently drops the bottom entry
            d.entry = {q.entry[DEPTH-2:0], pushData};
        end else if (pop) begin
            // underflow reads zero: the bottom refills with the reset word
            d.entry = {`CPU_RESET_WORD, q.entry[DEPTH-1:1]};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign top = q.entry[0];

endmodule : lifo_stack

// file: core/stack_cpu_sequencer.sv
// fetch, slot sequencing and execution core of the 24-bit dual-stack processor
`timescale 1ns/1ns
`include "stack_cpu_defines.svh"

// Functional notes
// - four 6-bit instructions per fetched word
// - top bit set: io bus read/write access
// - top bit clear: five-bit core opcode decode
// - data stack 17 deep, return 33
// - main registers are 24 bits wide
// - carry in own flip-flop until changed
// - memory read: address from A into T
// - memory write: address A, data T
// - slot counter picks instruction; rising edge updates
// - reset clears all; start at zero
// - idle or return forces fetch slot next
// - pending interrupt adds slot after fourth slot
// - seven prioritized lines, line zero vectors one
// - taking an interrupt disables further servicing
// - right shift keeps bit 23, shifts down
// - right shift: bit0 out, serial in carry
// - branches act only in first slot
// - branch replaces low 18 address bits
module stack_cpu_sequencer
    import stack_cpu_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    // program and data memory
    output mem_req_t                   memReq,
    input  wire word_t                 memRdData,
    // io bus
    output io_req_t                    ioReq,
    input  wire word_t                 ioRdData,
    // interrupt requests, line zero highest
    input  wire logic [`CPU_IRQ_N-1:0] irqReq,
    // serial pins
    input  wire logic                  serialIn,
    output logic                       serialOut
);

    cpu_state_t q;
    cpu_state_t d;

    logic                       dPush;
    logic                       dPop;
    logic                       rPush;
    logic                       rPop;
    word_t                      sTop;
    word_t                      rTop;
    logic [`CPU_OP_W-1:0]       curOp;
    logic [`CPU_CORE_OP_W-1:0]  coreOp;
    logic                       inFirst;
    word_t                      target;
    logic [`CPU_WORD_W:0]       sum;
    logic [`CPU_WORD_W:0]       mulStep;
    logic                       irqAny;
    logic [`CPU_IRQ_IDX_W-1:0]  irqIdx;
    word_t                      irqVector;
    slot_t                      afterSlot;

    // stacks below T and R; T and R make the 17th and 33rd levels
    lifo_stack #(
        .DEPTH    (`CPU_DSTACK_DEPTH)
    ) dataStack (
        .clock    (clock),
        .rst_b    (rst_b),
        .push     (dPush),
        .pop      (dPop),
        .pushData (q.t),
        .top      (sTop)
    );

    lifo_stack #(
        .DEPTH    (`CPU_RSTACK_DEPTH)
    ) returnStack (
        .clock    (clock),
        .rst_b    (rst_b),
        .push     (rPush),
        .pop      (rPop),
        .pushData (q.r),
        .top      (rTop)
    );

    // slot counter selects the 6-bit field, first slot in the top bits
    always_comb begin
        unique case (q.slot)
            SLOT_EXEC0: curOp = q.i[23:18];
            SLOT_EXEC1: curOp = q.i[17:12];
            SLOT_EXEC2: curOp = q.i[11:6];
            SLOT_EXEC3: curOp = q.i[5:0];
            default:    curOp = `CPU_OP_W'(`OP_IDLE);
        endcase
    end

    assign coreOp  = curOp[`CPU_CORE_OP_W-1:0];
    assign inFirst = (q.slot == SLOT_EXEC0);
    assign target  = {q.p[`CPU_WORD_W-1:`CPU_BRANCH_W], q.i[`CPU_BRANCH_W-1:0]};
    assign sum     = {1'b0, sTop} + {1'b0, q.t};
    assign mulStep = q.t[0] ? sum : {1'b0, q.t};

    // lowest-numbered pending line wins
    always_comb begin
        irqAny = 1'b0;
        irqIdx = '0;
        for (int k = `CPU_IRQ_N-1; k >= 0; k--) begin
            if (irqReq[k]) begin
                irqAny = 1'b1;
                irqIdx = `CPU_IRQ_IDX_W'(k);
            end
        end
    end

    assign irqVector = `CPU_IRQ_VEC_BASE + `CPU_WORD_W'(irqIdx);

    // interrupt slot only ever follows the fourth execution slot
    always_comb begin
        unique case (q.slot)
            SLOT_EXEC0: afterSlot = SLOT_EXEC1;
            SLOT_EXEC1: afterSlot = SLOT_EXEC2;
            SLOT_EXEC2: afterSlot = SLOT_EXEC3;
            SLOT_EXEC3: afterSlot = (irqAny && !q.irqMasked) ? SLOT_IRQ : SLOT_FETCH;
            default:    afterSlot = SLOT_FETCH;
        endcase
    end

    always_comb begin
        d              = q;
        dPush          = 1'b0;
        dPop           = 1'b0;
        rPush          = 1'b0;
        rPop           = 1'b0;
        memReq.addr    = q.a;
        memReq.wrData  = q.t;
        memReq.wrEn_b  = 1'b1;
        ioReq.addr     = curOp[`CPU_IO_ADDR_W-1:0];
        ioReq.wrData   = q.t;
        ioReq.wr       = 1'b0;
        ioReq.rd       = 1'b0;
        unique case (q.slot)
            SLOT_FETCH: begin
                memReq.addr = q.p;
                d.i         = memRdData;
                d.p         = q.p + `CPU_WORD_W'(1);
                d.slot      = SLOT_EXEC0;
            end
            SLOT_IRQ: begin
                rPush       = 1'b1;
                d.r         = q.p;
                d.p         = irqVector;
                d.irqMasked = 1'b1;
                d.slot      = SLOT_FETCH;
            end
            // execution slots; an illegal slot code decodes as idle and refetches
            default: begin
                d.slot = afterSlot;
                if (curOp[`CPU_IO_FLAG_BIT]) begin
                    // io write consumes T, io read pushes the answer
                    if (curOp[`CPU_IO_WRITE_BIT]) begin
                        ioReq.wr = 1'b1;
                        d.t      = sTop;
                        dPop     = 1'b1;
                    end else begin
                        ioReq.rd = 1'b1;
                        dPush    = 1'b1;
                        d.t      = ioRdData;
                    end
                end else begin
                    unique case (coreOp)
                        `OP_JUMP: begin
                            if (inFirst) begin
                                d.p    = target;
                                d.slot = SLOT_FETCH;
                            end
                        end
                        `OP_BRANCH_IF_ZERO: begin
                            if (inFirst) begin
                                if (q.t == `CPU_RESET_WORD) begin
                                    d.p = target;
                                end
                                d.t    = sTop;
                                dPop   = 1'b1;
                                d.slot = SLOT_FETCH;
                            end
                        end
                        `OP_BRANCH_NO_CY: begin
                            if (inFirst) begin
                                if (!q.carry) begin
                                    d.p = target;
                                end
                                d.slot = SLOT_FETCH;
                            end
                        end
                        `OP_CALL: begin
                            if (inFirst) begin
                                rPush  = 1'b1;
                                d.r    = q.p;
                                d.p    = target;
                                d.slot = SLOT_FETCH;
                            end
                        end
                        `OP_LOOP_NEXT: begin
                            if (inFirst) begin
                                if (q.r != `CPU_RESET_WORD) begin
                                    d.p = target;
                                    d.r = q.r - `CPU_WORD_W'(1);
                                end else begin
                                    d.r  = rTop;
                                    rPop = 1'b1;
                                end
                                d.slot = SLOT_FETCH;
                            end
                        end
                        `OP_REPEAT_WORD: begin
                            // reruns the cached word without a new fetch
                            if (q.r != `CPU_RESET_WORD) begin
                                d.r    = q.r - `CPU_WORD_W'(1);
                                d.slot = SLOT_EXEC0;
                            end else begin
                                d.r  = rTop;
                                rPop = 1'b1;
                            end
                        end
                        `OP_RETURN: begin
                            d.p    = q.r;
                            d.r    = rTop;
                            rPop   = 1'b1;
                            d.slot = SLOT_FETCH;
                        end
                        `OP_INTERRUPT_EXIT: begin
                            d.p         = q.r;
                            d.r         = rTop;
                            rPop        = 1'b1;
                            d.irqMasked = 1'b0;
                            d.slot      = SLOT_FETCH;
                        end
                        `OP_IDLE:       d.slot = SLOT_FETCH;
                        `OP_ROTATE8:    d.t = {q.t[7:0], q.t[23:8]};
                        `OP_LOAD_INC: begin
                            dPush = 1'b1;
                            d.t   = memRdData;
                            d.a   = q.a + `CPU_WORD_W'(1);
                        end
                        `OP_LOAD: begin
                            dPush = 1'b1;
                            d.t   = memRdData;
                        end
                        `OP_LITERAL: begin
                            // literal sits in the word after the current one
                            memReq.addr = q.p;
                            dPush       = 1'b1;
                            d.t         = memRdData;
                            d.p         = q.p + `CPU_WORD_W'(1);
                        end
                        `OP_STORE,
                        `OP_STORE_ALT,
                        `OP_STORE_INC: begin
                            memReq.wrEn_b = 1'b0;
                            d.t           = sTop;
                            dPop          = 1'b1;
                            if (coreOp == `OP_STORE_INC) begin
                                d.a = q.a + `CPU_WORD_W'(1);
                            end
                        end
                        `OP_RESERVED:   d.slot = afterSlot;
                        `OP_COMPLEMENT: d.t = ~q.t;
                        `OP_SHIFT_LEFT: begin
                            d.carry = q.t[23];
                            d.t     = {q.t[22:0], 1'b0};
                        end
                        `OP_RIGHT_SHIFT: begin
                            d.t         = {q.t[23], q.t[23:1]};
                            d.serialOut = q.t[0];
                            d.carry     = serialIn;
                        end
                        `OP_MUL_STEP: begin
                            d.t     = mulStep[`CPU_WORD_W:1];
                            d.carry = mulStep[0];
                        end
                        `OP_XOR: begin
                            d.t  = sTop ^ q.t;
                            dPop = 1'b1;
                        end
                        `OP_AND: begin
                            d.t  = sTop & q.t;
                            dPop = 1'b1;
                        end
                        `OP_NIP:        dPop = 1'b1;
                        `OP_ADD: begin
                            d.t     = sum[`CPU_WORD_W-1:0];
                            d.carry = sum[`CPU_WORD_W];
                            dPop    = 1'b1;
                        end
                        `OP_POP_RET: begin
                            dPush = 1'b1;
                            d.t   = q.r;
                            d.r   = rTop;
                            rPop  = 1'b1;
                        end
                        `OP_FETCH_ADDR: begin
                            dPush = 1'b1;
                            d.t   = q.a;
                        end
                        `OP_DUP:        dPush = 1'b1;
                        `OP_OVER: begin
                            dPush = 1'b1;
                            d.t   = sTop;
                        end
                        `OP_PUSH_RET: begin
                            rPush = 1'b1;
                            d.r   = q.t;
                            d.t   = sTop;
                            dPop  = 1'b1;
                        end
                        `OP_SET_ADDR: begin
                            d.a  = q.t;
                            d.t  = sTop;
                            dPop = 1'b1;
                        end
                        `OP_DROP: begin
                            d.t  = sTop;
                            dPop = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    // all registers load on the rising edge; reset leaves P at zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign serialOut = q.serialOut;

endmodule : stack_cpu_sequencer

// file: sim/cpu_checker.sv
// port assertions for the stack processor sequencer
`timescale 1ns/1ns
`include "stack_cpu_defines.svh"
module cpu_checker
    import stack_cpu_pkg::*;
(
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rst_b,
    // program and data memory
    input wire mem_req_t              memReq,
    input wire word_t                 memRdData,
    // io bus
    input wire io_req_t               ioReq,
    input wire word_t                 ioRdData,
    // interrupts and serial pins
    input wire logic [`CPU_IRQ_N-1:0] irqReq,
    input wire logic                  serialIn,
    input wire logic                  serialOut
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    a_start_at_zero: assert property ($rose(rst_b) |-> memReq.addr == 24'h000000)
        else $error("first fetch not at address zero");
    a_reset_cleared: assert property ($rose(rst_b) |-> $past(memReq.wrEn_b) &&
        $past(memReq.wrData) == 24'h000000 && !$past(serialOut) && !$past(ioReq.wr) && !$past(ioReq.rd))
        else $error("outputs not cleared during reset");
    a_io_exclusive: assert property (ioReq.wr |-> !ioReq.rd)
        else $error("io read and write together");
    a_io_read_push: assert property (ioReq.rd |=> memReq.wrData == $past(ioRdData))
        else $error("io read data not in accumulator");
    a_t_shared: assert property (memReq.wrData == ioReq.wrData)
        else $error("memory and io write data differ");
    a_io_no_store: assert property (!memReq.wrEn_b |-> !ioReq.wr && !ioReq.rd)
        else $error("memory write during io slot");
    a_serial_from_t: assert property ($changed(serialOut) |-> serialOut == $past(memReq.wrData[0]))
        else $error("serial output not accumulator bit 0");
    a_shift_sign: assert property ($changed(serialOut) |->
        memReq.wrData == {$past(memReq.wrData[23]), $past(memReq.wrData[23:1])})
        else $error("right shift result wrong");

    c_io_read: cover property (ioReq.rd);
    c_mem_write: cover property (!memReq.wrEn_b);
    c_serial_change: cover property ($changed(serialOut));
endmodule : cpu_checker

bind stack_cpu_sequencer cpu_checker u_checker (
    .clock     (clock),
    .rst_b     (rst_b),
    .memReq    (memReq),
    .memRdData (memRdData),
    .ioReq     (ioReq),
    .ioRdData  (ioRdData),
    .irqReq    (irqReq),
    .serialIn  (serialIn),
    .serialOut (serialOut)
);

// file: sim/program_memory.sv
// zero-wait program and data memory on the sequencer's memory port
`timescale 1ns/1ns
module program_memory
    import stack_cpu_pkg::*;
(
    // clock
    input  wire logic     clock,
    // memory port
    input  wire mem_req_t memReq,
    output word_t         memRdData
);
    word_t ram [256];

    // only 256 words: higher addresses alias, so programs stay low
    assign memRdData = ram[memReq.addr[7:0]];

    always @(posedge clock) begin
        if (memReq.wrEn_b === 1'b0) begin
            ram[memReq.addr[7:0]] <= memReq.wrData;
        end
    end
endmodule : program_memory

// file: sim/testbench.sv
// bench: program and interrupt runs through the sequencer, bus events checked
`timescale 1ns/1ns
`include "stack_cpu_defines.svh"
module testbench
    import stack_cpu_pkg::*;
;
    logic                  clock     = 1'b0;
    logic                  rst_b     = 1'b0;
    mem_req_t              memReq;
    word_t                 memRdData;
    io_req_t               ioReq;
    word_t                 ioRdData  = 24'h000000;
    logic [`CPU_IRQ_N-1:0] irqReq    = 7'h00;
    logic                  serialIn  = 1'b0;
    logic                  serialOut;
    int                    numErrors = 0;
    int                    nCompared = 0;
    integer                seed      = 32'hFE4F;
    logic [49:0]           expQ[$];

    always #2 clock = ~clock;

    stack_cpu_sequencer DUT (
        .clock     (clock),
        .rst_b     (rst_b),
        .memReq    (memReq),
        .memRdData (memRdData),
        .ioReq     (ioReq),
        .ioRdData  (ioRdData),
        .irqReq    (irqReq),
        .serialIn  (serialIn),
        .serialOut (serialOut)
    );

    program_memory mem (
        .clock     (clock),
        .memReq    (memReq),
        .memRdData (memRdData)
    );

    function automatic logic [5:0] op(input logic [4:0] o);
        return {1'b0, o};
    endfunction : op

    task automatic check(input string what, input logic [49:0] seen, input logic [49:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (numErrors == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic note(input string what, input logic [49:0] seen);
        // an event with nothing expected compares against zero and fails
        if (expQ.size() == 0) begin
            check(what, seen, 50'h0);
        end else begin
            check(what, seen, expQ.pop_front());
        end
    endtask : note

    always @(posedge clock) begin
        if (rst_b && memReq.wrEn_b === 1'b0) begin
            note("memory write", {2'h1, memReq.addr, memReq.wrData});
        end
        if (rst_b && ioReq.wr !== 1'b0) begin
            note("io write", {2'h2, 20'h00000, ioReq.addr, ioReq.wrData});
        end
    end

    task automatic mw(input word_t d);
        expQ.push_back({2'h1, 24'h000080, d});
    endtask : mw

    task automatic iw(input logic [3:0] a, input word_t d);
        expQ.push_back({2'h2, 20'h00000, a, d});
    endtask : iw

    task automatic wait_drain();
        int n;
        for (n = 0; n < 400 && expQ.size() > 0; n++) begin
            @(posedge clock);
            #1;
        end
        if (expQ.size() > 0) begin
            numErrors++;
            close_out();
        end
    endtask : wait_drain

    // the line stays up past the handler's fourth slot, so a missing mask re-enters
    task automatic wait_io(input int k);
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge clock);
            if (ioReq.wr === 1'b1 && ioReq.addr === 4'(k)) break;
        end
        if (n == 400) begin
            numErrors++;
            close_out();
        end else begin
            repeat (2) @(posedge clock);
            #1 irqReq[k] = 1'b0;
        end
    endtask : wait_io

    task automatic run_pass(input logic p);
        logic [5:0] lit;
        logic [5:0] st;
        logic [5:0] idle;
        word_t      d0;
        word_t      d1;
        word_t      d2;
        word_t      c1;
        word_t      v[7];
        rst_b    = 1'b0;
        lit      = op(`OP_LITERAL);
        st       = op(`OP_STORE);
        idle     = op(`OP_IDLE);
        d0       = word_t'($random(seed));
        d1       = word_t'($random(seed));
        d2       = {1'b1, 22'($random(seed)), p};
        c1       = word_t'($random(seed));
        ioRdData = word_t'($random(seed));
        serialIn = p;
        mem.ram[0] = {1'b0, `OP_JUMP, 18'h00010};
        for (int k = 0; k < 7; k++) begin
            v[k] = word_t'($random(seed));
            mem.ram[1 + k] = {1'b0, `OP_JUMP, 18'(48 + 3 * k)};
            mem.ram[48 + 3 * k] = {lit, 2'b11, 4'(k), op(`OP_DUP), op(`OP_DROP)};
            mem.ram[49 + 3 * k] = v[k];
            mem.ram[50 + 3 * k] = {op(`OP_INTERRUPT_EXIT), idle, idle, idle};
        end
        mem.ram[16] = {lit, op(`OP_SET_ADDR), lit, st};
        mem.ram[17] = 24'h000080;
        mem.ram[18] = d0;
        mem.ram[19] = {lit, 6'h35, idle, st};
        mem.ram[20] = d1;
        mem.ram[21] = {6'h23, op(`OP_JUMP), st, idle};
        mem.ram[22] = {lit, op(`OP_RIGHT_SHIFT), st, idle};
        mem.ram[23] = d2;
        mem.ram[24] = {1'b0, `OP_BRANCH_NO_CY, 18'h0001B};
        mem.ram[25] = {lit, st, idle, idle};
        mem.ram[26] = c1;
        mem.ram[27] = {op(`OP_LOAD), st, idle, idle};
        mem.ram[28] = {1'b0, `OP_JUMP, 18'h0001D};
        mem.ram[29] = {op(`OP_DUP), op(`OP_DROP), op(`OP_DUP), op(`OP_DROP)};
        mem.ram[30] = {1'b0, `OP_JUMP, 18'h0001D};
        mw(d0);
        iw(4'h5, d1);
        mw(ioRdData);
        mw({d2[23], d2[23:1]});
        if (p) mw(c1);
        mw(p ? c1 : {d2[23], d2[23:1]});
        repeat (2) @(posedge clock);
        #1 rst_b = 1'b1;
        wait_drain();
        check("serial output", {49'h0, serialOut}, {49'h0, p});
        for (int k = 0; k < 7; k++) begin
            iw(4'(k), v[k]);
            irqReq[k] = 1'b1;
            wait_io(k);
        end
        iw(4'h0, v[0]);
        iw(4'h6, v[6]);
        irqReq = 7'h41;
        wait_io(0);
        wait_io(6);
        wait_drain();
    endtask : run_pass

    initial begin
        for (int pass = 0; pass < 2; pass++) begin
            run_pass(pass[0]);
        end
        close_out();
    end
endmodule : testbench
